// ===== hdl/keyed_watchdog_timer.sv
// Keyed watchdog timer with APB register slave and expiry outputs
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns

// Contract
// - 16-bit counter decrements on each selected tick while enabled.
// - Tick sources are master clock divided by 32, 128, 1024, 4096.
// - Select field bits 1:0 of tick config picks the divider.
// - Restart loads 0xFFF low and preload high nibble into bits 15:12.
// - Disabled timer produces no outputs; enabled drives only enabled outputs.
// - Overflow with reset enable raises internal reset request.
// - Overflow with interrupt enable pulses the interrupt line.
// - Overflow with pin enable drives expiry pin low for 8 cycles.
// - Mode and tick config updates need the key in the same write.
// - Mode write accepted only with key 0x234 in bits 15:4; key reads zero.
// - Tick config write accepted only with key 0x06E in bits 15:7; reads zero.
// - Writing 0xC071 to restart register restarts counter; others ignored.
// - Overflow flag set on overflow, cleared by restart or reset.
// - Watchdog comes out of reset disabled.
module keyed_watchdog_timer
   import watchdog_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [4:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic internal_reset_request,
   output logic expiry_interrupt_line,
   output logic expiry_pin_n,
   output logic irq
);

   logic [3:0] mode;
   logic [5:0] tick_config;
   logic [15:0] count;
   logic [11:0] prescale;
   logic [11:0] next_prescale;
   logic expiry_flag;
   logic irq_enable;
   logic irq_status;
   logic [3:0] pin_count;
   logic tick;
   logic expire;
   logic restart;
   logic wr;
   logic rd;
   logic bank;

   // Write decoded in access phase, read in setup phase; upper address bit selects the interrupt bank
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign bank = paddr[4];
   assign next_prescale = prescale + 12'h001;

   // Tick when the prescaler wraps at the selected divider
   function automatic logic tick_at(input logic [11:0] p, input logic [1:0] sel);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         2'b00: hit = (p[div_32_log-1:0] == '1);
         2'b01: hit = (p[div_128_log-1:0] == '1);
         2'b10: hit = (p[div_1024_log-1:0] == '1);
         2'b11: hit = (p[div_4096_log-1:0] == '1);
      endcase
      return hit;
   endfunction

   assign tick = tick_at(prescale, tick_config[1:0]);
   assign restart = wr && !bank && paddr[3:0] == restart_control_offset
      && pwdata[15:0] == restart_key;
   assign expire = mode[timer_enable_pos] && tick && count == 16'h0000 && !restart;

   // Free running prescaler from the master clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= 12'h000;
      end else begin
         prescale <= next_prescale;
      end
   end

   // Keyed mode register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= mode_reset;
      end else if (wr && !bank && paddr[3:0] == expiry_mode_offset
            && pwdata[15:4] == mode_write_key) begin
         mode <= pwdata[3:0];
      end
   end

   // Keyed tick configuration write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_config <= tick_config_reset;
      end else if (wr && !bank && paddr[3:0] == tick_config_offset
            && pwdata[15:7] == tick_config_write_key) begin
         tick_config <= pwdata[5:0];
      end
   end

   // Down counter with restart preload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= {4'hf, preload_low_bits};
      end else if (restart) begin
         count <= {tick_config[5:2], preload_low_bits};
      end else if (mode[timer_enable_pos] && tick) begin
         count <= count - 16'h0001;
      end
   end

   // Overflow flag, restart clears it and masks an overflow in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         expiry_flag <= 1'b0;
      end else if (expire) begin
         expiry_flag <= 1'b1;
      end else if (restart) begin
         expiry_flag <= 1'b0;
      end
   end

   // Reset request and interrupt pulses, one cycle per overflow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         internal_reset_request <= 1'b0;
         expiry_interrupt_line <= 1'b0;
      end else begin
         internal_reset_request <= expire && mode[reset_on_expiry_pos];
         expiry_interrupt_line <= expire && mode[interrupt_on_expiry_pos];
      end
   end

   // Expiry pin held low for a fixed number of cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_count <= 4'h0;
         expiry_pin_n <= 1'b1;
      end else if (expire && mode[pin_pulse_on_expiry_pos]) begin
         pin_count <= 4'(pin_pulse_cycles - 1);
         expiry_pin_n <= 1'b0;
      end else if (pin_count != 4'h0) begin
         pin_count <= pin_count - 4'h1;
         expiry_pin_n <= 1'b0;
      end else begin
         expiry_pin_n <= 1'b1;
      end
   end

   // Sticky interrupt status, enable and clear; set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable <= 1'b0;
         irq_status <= 1'b0;
      end else begin
         if (wr && bank && paddr[3:0] == irq_enable_offset) begin
            irq_enable <= pwdata[0];
         end
         if (expire) begin
            irq_status <= 1'b1;
         end else if (wr && bank && paddr[3:0] == irq_clear_offset && pwdata[0]) begin
            irq_status <= 1'b0;
         end
      end
   end

   // Level interrupt output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_status && irq_enable;
      end
   end

   // Read data captured in setup, ready in access; keys read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (bank ? paddr[3] : 1'b0);
         if (rd) begin
            prdata <= 32'h00000000;
            if (!bank) begin
               unique case (paddr[3:0])
                  expiry_mode_offset: prdata <= {28'h0, mode};
                  tick_config_offset: prdata <= {26'h0, tick_config};
                  expiry_status_offset: prdata <= {31'h0, expiry_flag};
                  default: prdata <= 32'h00000000;
               endcase
            end else begin
               unique case (paddr[3:0])
                  irq_enable_offset: prdata <= {31'h0, irq_enable};
                  4'h8: prdata <= {31'h0, irq_status};
                  default: prdata <= 32'h00000000;
               endcase
            end
         end
      end
   end

endmodule

// ===== hdl/watchdog_pkg.sv
// Package with register map, field layout and constants of the keyed watchdog
package watchdog_pkg;
   localparam logic [3:0] expiry_mode_offset = 4'h0;
   localparam logic [3:0] tick_config_offset = 4'h4;
   localparam logic [3:0] restart_control_offset = 4'h8;
   localparam logic [3:0] expiry_status_offset = 4'hc;
   localparam logic [3:0] irq_enable_offset = 4'h0;
   localparam logic [3:0] irq_clear_offset = 4'h4;
   localparam logic [11:0] mode_write_key = 12'h234;
   localparam logic [8:0] tick_config_write_key = 9'h06e;
   localparam logic [15:0] restart_key = 16'hc071;
   localparam int timer_enable_pos = 0;
   localparam int reset_on_expiry_pos = 1;
   localparam int interrupt_on_expiry_pos = 2;
   localparam int pin_pulse_on_expiry_pos = 3;
   localparam logic [11:0] preload_low_bits = 12'hfff;
   localparam logic [3:0] mode_reset = 4'h0;
   localparam logic [5:0] tick_config_reset = 6'h00;
   localparam int pin_pulse_cycles = 8;
   localparam int div_32_log = 5;
   localparam int div_128_log = 7;
   localparam int div_1024_log = 10;
   localparam int div_4096_log = 12;
endpackage

// ===== testbench/wd_sva.sv
// Checker of bus timing, read-back layout and expiry outputs
`timescale 1ns/1ns
module wd_sva (
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic internal_reset_request, expiry_interrupt_line, expiry_pin_n, irq,
   input wire logic [4:0] paddr,
   input wire logic [31:0] prdata
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Read answer strobe
   wire rd = pready && !pwrite;
   property p_ans; psel && !penable |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("late answer");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("long answer");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("stray error");
   property p_pin; $fell(expiry_pin_n) |-> !expiry_pin_n [*8] ##1 expiry_pin_n; endproperty
   a_pin: assert property (p_pin) else $error("pin width");
   property p_rst; internal_reset_request |=> !internal_reset_request; endproperty
   a_rst: assert property (p_rst) else $error("reset width");
   property p_int; expiry_interrupt_line |=> !expiry_interrupt_line; endproperty
   a_int: assert property (p_int) else $error("pulse width");
   property p_mode; rd && paddr == 5'h00 |-> prdata[31:4] == 28'h0; endproperty
   a_mode: assert property (p_mode) else $error("mode key seen");
   property p_tick; rd && paddr == 5'h04 |-> prdata[31:6] == 26'h0; endproperty
   a_tick: assert property (p_tick) else $error("tick key seen");
   property p_stat; rd && paddr == 5'h0c |-> prdata[31:1] == 31'h0; endproperty
   a_stat: assert property (p_stat) else $error("status layout");
   c_pin: cover property ($fell(expiry_pin_n));
   c_int: cover property (expiry_interrupt_line);
   c_err: cover property (pslverr);
endmodule

// ===== testbench/keyed_watchdog_timer_bench.sv
// Bench driving the keyed watchdog over its register bus
`timescale 1ns/1ns
`define chk(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
$display("[ERR] %0t got %h want %h", $time, a, b); end end
module keyed_watchdog_timer_bench;
   import watchdog_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [4:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, internal_reset_request, expiry_interrupt_line;
   logic expiry_pin_n, irq;
   int n_fail = 0, tests_run = 0, k;
   keyed_watchdog_timer u_keyed_watchdog_timer (.*);
   // Clock of 10 ns
   always #5 pclk = ~pclk;
   // One transfer, released after the answer edge
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   // Verdict and end of run
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #2000000;
      n_fail++;
      wrap_up;
   end
   // Test sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      xfer(0, 5'h00, 0);
      `chk(rd, 32'h0)
      xfer(1, 5'h00, 32'h123f);
      xfer(1, 5'h04, 32'h003f);
      xfer(0, 5'h00, 0);
      `chk(rd, 32'h0)
      xfer(0, 5'h04, 0);
      `chk(rd, 32'h0)
      for (k = 0; k < 4; k++) begin
         xfer(1, 5'h04, 32'h3700 | k);
         xfer(0, 5'h04, 0);
         `chk(rd, k)
      end
      xfer(1, 5'h04, 32'h373c);
      xfer(0, 5'h04, 0);
      `chk(rd, 32'h3c)
      xfer(0, 5'h1c, 0);
      `chk(err, 1'b1)
      $display("Keys done");
      xfer(1, 5'h04, 32'h3700);
      xfer(1, 5'h10, 32'h1);
      xfer(1, 5'h00, 32'h234f);
      xfer(1, 5'h08, 32'hc071);
      for (k = 0; k < 140000 && expiry_interrupt_line !== 1; k++) @(posedge pclk);
      `chk(k > 4095 * 32 - 2 && k <= 4097 * 32, 1'b1)
      `chk(internal_reset_request, 1'b1)
      `chk(expiry_pin_n, 1'b0)
      xfer(0, 5'h0c, 0);
      `chk(rd, 32'h1)
      `chk(irq, 1'b1)
      xfer(1, 5'h10, 32'h0);
      repeat (2) @(posedge pclk);
      `chk(irq, 1'b0)
      xfer(1, 5'h10, 32'h1);
      xfer(1, 5'h14, 32'h1);
      repeat (2) @(posedge pclk);
      `chk(irq, 1'b0)
      xfer(1, 5'h08, 32'hc070);
      xfer(0, 5'h0c, 0);
      `chk(rd, 32'h1)
      xfer(1, 5'h08, 32'hc071);
      xfer(0, 5'h0c, 0);
      `chk(rd, 32'h0)
      $display("Expiry done");
      wrap_up;
   end
endmodule
bind keyed_watchdog_timer wd_sva u_wd_sva (.*);
